//--- verilog/flash_mode_pkg.sv
package flash_mode_pkg;

	// system clock and reset recovery time
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_TIME_US   = 30;
	localparam int RST_CYCLES    = (RST_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 12;
	localparam logic [CNT_W-1:0] RST_COUNT = RST_CYCLES[CNT_W-1:0];

	// opcodes
	localparam logic [7:0] OP_EXIT_QUAD    = 8'hff;
	localparam logic [7:0] OP_ENTER_QUAD   = 8'h38;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET        = 8'h99;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_READ_PARAM = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CONT_READ  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_WRAP       = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_VOL_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h14;

	// field positions
	localparam int CTRL_QE_BIT     = 0;
	localparam int CTRL_WEL_BIT    = 1;
	localparam int CTRL_SUS_BIT    = 2;
	localparam int ST_QUAD_BIT     = 0;
	localparam int ST_RST_EN_BIT   = 1;
	localparam int ST_RECOVER_BIT  = 2;
	localparam int ST_LAST_OP_LSB  = 8;

	// values after reset
	localparam logic       QE_RESET   = 1'b0;
	localparam logic [7:0] RP_RESET   = 8'h00;
	localparam logic [7:0] CRM_RESET  = 8'h00;
	localparam logic [2:0] WRAP_RESET = 3'h0;
	localparam logic [7:0] VSR_RESET  = 8'h00;

	// link clock counts within a frame (zero based)
	localparam logic [3:0] QUAD_LAST_CLK   = 4'h1;
	localparam logic [3:0] SERIAL_LAST_CLK = 4'h7;

	typedef enum logic {
		MODE_SERIAL = 1'b0,
		MODE_QUAD   = 1'b1
	} mode_t;

endpackage

//--- verilog/level_sync.sv
module level_sync
	import flash_mode_pkg::*;
#(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_i,     // destination clock
	input  wire logic             reset_n_i, // async reset, active low
	input  wire logic             en_i,      // clock enable
	input  wire logic [WIDTH-1:0] d_i,       // level from other domain
	output logic      [WIDTH-1:0] q_o        // synchronised level
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (en_i) begin
			st_nxt.s1 = d_i;
			st_nxt.s2 = st_r.s1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.s2;

endmodule

//--- verilog/cmd_shift_in.sv
module cmd_shift_in
	import flash_mode_pkg::*;
(
	input  wire logic       link_clk_i,    // serial clock from host
	input  wire logic       reset_n_i,     // async reset, active low
	input  wire logic       cs_n_i,        // chip select, active low
	input  wire logic [3:0] io_i,          // data lines, io0 is serial input
	output logic      [7:0] quad_byte_o,   // opcode as four-line byte
	output logic      [7:0] serial_byte_o, // opcode as one-line byte
	output logic      [1:0] toggle_o       // bit0 quad, bit1 serial event
);

	typedef struct packed {
		logic [3:0] clk_cnt;
		logic [3:0] quad_sh;
		logic [6:0] ser_sh;
	} frame_t;

	typedef struct packed {
		logic [7:0] quad_byte;
		logic [7:0] serial_byte;
		logic [1:0] toggle;
	} hold_t;

	frame_t fr_r;
	frame_t fr_nxt;
	hold_t  hd_r;
	hold_t  hd_nxt;
	logic   frame_rst_n;

	// the link clock stops between frames, so the frame state is cleared by select itself
	assign frame_rst_n = reset_n_i & ~cs_n_i;

	always_comb begin
		fr_nxt = fr_r;
		fr_nxt.quad_sh = io_i;
		fr_nxt.ser_sh = {fr_r.ser_sh[5:0], io_i[0]};
		if (fr_r.clk_cnt != 4'hf) begin
			fr_nxt.clk_cnt = fr_r.clk_cnt + 4'h1;
		end
	end

	// both decodings are offered; the system side picks the one of its mode
	always_comb begin
		hd_nxt = hd_r;
		if (fr_r.clk_cnt == QUAD_LAST_CLK) begin
			hd_nxt.quad_byte = {fr_r.quad_sh, io_i};
			hd_nxt.toggle[0] = ~hd_r.toggle[0];
		end
		if (fr_r.clk_cnt == SERIAL_LAST_CLK) begin
			hd_nxt.serial_byte = {fr_r.ser_sh, io_i[0]};
			hd_nxt.toggle[1] = ~hd_r.toggle[1];
		end
	end

	always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			fr_r <= '0;
		end else begin
			fr_r <= fr_nxt;
		end
	end

	always_ff @(posedge link_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hd_r <= '0;
		end else begin
			hd_r <= hd_nxt;
		end
	end

	assign quad_byte_o   = hd_r.quad_byte;
	assign serial_byte_o = hd_r.serial_byte;
	assign toggle_o      = hd_r.toggle;

endmodule

//--- verilog/flash_mode_ctrl.sv
// Function
// R1: opcode FFh leaves quad command mode
// R2: leaving quad mode keeps latch, suspend, wrap
// R3: accepted reset aborts and clears volatile settings
// R4: 66h and 99h accepted in both modes
// R5: reset only when 66h directly precedes 99h
// R6: any other command cancels reset enable
// R7: host resends full pair after a cancel
// R8: about 30 us recovery ignoring all commands
// R9: host checks busy and suspend before reset
// R10: reset only via command pair, no pin
// R11: 38h ignored while quad enable is zero
// R12: reset enable cleared at power-up and after reset
module flash_mode_ctrl
	import flash_mode_pkg::*;
(
	input  wire logic              sys_clk_i,    // system clock, 100 MHz
	input  wire logic              reset_n_i,    // async reset, active low
	input  wire logic              en_i,         // clock enable; when low state holds, but rdata_o and op_abort_o go low
	input  wire logic              link_clk_i,   // serial clock from host
	input  wire logic              cs_n_i,       // chip select, active low
	input  wire logic [3:0]        io_i,         // data lines from host
	input  wire logic [ADDR_W-1:0] addr_i,       // register address
	input  wire logic [DATA_W-1:0] wdata_i,      // register write data
	input  wire logic              wr_i,         // write strobe
	input  wire logic              rd_i,         // read strobe
	output logic      [DATA_W-1:0] rdata_o,      // read data, cycle after strobe
	output logic                   quad_mode_o,  // quad command mode active
	output logic                   reset_busy_o, // reset recovery in progress
	output logic                   op_abort_o    // pulse: abort internal operation
);

	typedef struct packed {
		mode_t             mode;
		logic              reset_enabled;
		logic              skip_serial;
		logic [CNT_W-1:0]  recover_cnt;
		logic              quad_enable_bit;
		logic              write_enable_latch;
		logic              suspend_status_bit;
		logic [7:0]        read_parameter_bits;
		logic [7:0]        continuous_read_mode_bits;
		logic [2:0]        wrap_setting_bits;
		logic [7:0]        volatile_status;
		logic [7:0]        last_opcode;
		logic              abort;
		logic [1:0]        tog_seen;
		logic [DATA_W-1:0] rdata;
	} state_t;

	localparam state_t STATE_INIT = '{
		mode:                      MODE_SERIAL,
		reset_enabled:             1'b0,
		skip_serial:               1'b0,
		recover_cnt:               '0,
		quad_enable_bit:           QE_RESET,
		write_enable_latch:        1'b0,
		suspend_status_bit:        1'b0,
		read_parameter_bits:       RP_RESET,
		continuous_read_mode_bits: CRM_RESET,
		wrap_setting_bits:         WRAP_RESET,
		volatile_status:           VSR_RESET,
		last_opcode:               8'h00,
		abort:                     1'b0,
		tog_seen:                  2'b00,
		rdata:                     '0
	};

	state_t st_r;
	state_t st_nxt;

	logic [7:0] quad_byte;
	logic [7:0] serial_byte;
	logic [1:0] tog_link;
	logic [1:0] tog_sync;
	logic [1:0] tog_new;
	logic       ev_valid;
	logic [7:0] ev_op;
	logic       busy;
	logic       take;
	logic       reset_fire;
	logic       wr_en;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		hit = (a == r);
	endfunction

	cmd_shift_in u_cmd_shift_in (
		.link_clk_i    (link_clk_i),
		.reset_n_i     (reset_n_i),
		.cs_n_i        (cs_n_i),
		.io_i          (io_i),
		.quad_byte_o   (quad_byte),
		.serial_byte_o (serial_byte),
		.toggle_o      (tog_link)
	);

	// bytes stay stable for a whole frame, so only the toggles need synchronising
	level_sync #(
		.WIDTH (2)
	) u_level_sync (
		.clk_i     (sys_clk_i),
		.reset_n_i (reset_n_i),
		.en_i      (en_i),
		.d_i       (tog_link),
		.q_o       (tog_sync)
	);

	assign tog_new = tog_sync ^ st_r.tog_seen;
	assign busy    = (st_r.recover_cnt != '0);
	assign wr_en   = wr_i & en_i;

	// a quad frame long enough to also raise the serial event must not be replayed
	always_comb begin
		if (st_r.mode == MODE_QUAD) begin
			ev_valid = en_i & tog_new[0];
			ev_op    = quad_byte;
		end else begin
			ev_valid = en_i & tog_new[1] & ~st_r.skip_serial;
			ev_op    = serial_byte;
		end
	end

	assign take       = ev_valid & ~busy; // R8
	assign reset_fire = take & (ev_op == OP_RESET) & st_r.reset_enabled; // R5 R10

	always_comb begin
		st_nxt = st_r;
		st_nxt.abort = 1'b0;
		st_nxt.rdata = '0;
		if (en_i) begin
			st_nxt.tog_seen = tog_sync;
			if (tog_new[0]) begin
				st_nxt.skip_serial = 1'b0;
			end
			if (tog_new[1]) begin
				st_nxt.skip_serial = 1'b0;
			end
		end
		// software side stands in for the commands outside this block
		if (wr_en) begin
			if (hit(addr_i, ADDR_CTRL)) begin
				st_nxt.quad_enable_bit    = wdata_i[CTRL_QE_BIT];
				st_nxt.write_enable_latch = wdata_i[CTRL_WEL_BIT];
				st_nxt.suspend_status_bit = wdata_i[CTRL_SUS_BIT];
			end
			if (hit(addr_i, ADDR_READ_PARAM)) begin
				st_nxt.read_parameter_bits = wdata_i[7:0];
			end
			if (hit(addr_i, ADDR_CONT_READ)) begin
				st_nxt.continuous_read_mode_bits = wdata_i[7:0];
			end
			if (hit(addr_i, ADDR_WRAP)) begin
				st_nxt.wrap_setting_bits = wdata_i[2:0];
			end
			if (hit(addr_i, ADDR_VOL_STATUS)) begin
				st_nxt.volatile_status = wdata_i[7:0];
			end
		end
		if (rd_i && en_i) begin
			if (hit(addr_i, ADDR_CTRL)) begin
				st_nxt.rdata[CTRL_QE_BIT]  = st_r.quad_enable_bit;
				st_nxt.rdata[CTRL_WEL_BIT] = st_r.write_enable_latch;
				st_nxt.rdata[CTRL_SUS_BIT] = st_r.suspend_status_bit;
			end
			if (hit(addr_i, ADDR_READ_PARAM)) begin
				st_nxt.rdata[7:0] = st_r.read_parameter_bits;
			end
			if (hit(addr_i, ADDR_CONT_READ)) begin
				st_nxt.rdata[7:0] = st_r.continuous_read_mode_bits;
			end
			if (hit(addr_i, ADDR_WRAP)) begin
				st_nxt.rdata[2:0] = st_r.wrap_setting_bits;
			end
			if (hit(addr_i, ADDR_VOL_STATUS)) begin
				st_nxt.rdata[7:0] = st_r.volatile_status;
			end
			if (hit(addr_i, ADDR_STATUS)) begin
				st_nxt.rdata[ST_QUAD_BIT]    = (st_r.mode == MODE_QUAD);
				st_nxt.rdata[ST_RST_EN_BIT]  = st_r.reset_enabled;
				st_nxt.rdata[ST_RECOVER_BIT] = busy;
				st_nxt.rdata[ST_LAST_OP_LSB +: 8] = st_r.last_opcode;
			end
		end
		if (en_i && busy) begin
			st_nxt.recover_cnt = st_r.recover_cnt - 1'b1; // R8
			if (st_r.recover_cnt == 1) begin
				st_nxt.reset_enabled = 1'b0; // R12
			end
		end
		// 66h and 99h are decoded identically in either mode; 38h and FFh depend on it
		if (take) begin // R4
			st_nxt.last_opcode = ev_op;
			if (ev_op == OP_RESET_ENABLE) begin
				st_nxt.reset_enabled = 1'b1; // R4
			end else if (reset_fire) begin
				// clears win over a software write in the same cycle
				st_nxt.mode                      = MODE_SERIAL; // R3
				st_nxt.reset_enabled             = 1'b0;
				st_nxt.skip_serial               = (st_r.mode == MODE_QUAD);
				st_nxt.recover_cnt               = RST_COUNT; // R8
				st_nxt.write_enable_latch        = 1'b0; // R3
				st_nxt.suspend_status_bit        = 1'b0; // R3
				st_nxt.read_parameter_bits       = RP_RESET; // R3
				st_nxt.continuous_read_mode_bits = CRM_RESET; // R3
				st_nxt.wrap_setting_bits         = WRAP_RESET; // R3
				st_nxt.volatile_status           = VSR_RESET; // R3
				st_nxt.abort                     = 1'b1; // R3
			end else begin
				st_nxt.reset_enabled = 1'b0; // R6
				if (st_r.mode == MODE_QUAD && ev_op == OP_EXIT_QUAD) begin
					// latch, suspend and wrap are left untouched
					st_nxt.mode        = MODE_SERIAL; // R1 R2
					st_nxt.skip_serial = 1'b1;
				end
				if (st_r.mode == MODE_SERIAL && ev_op == OP_ENTER_QUAD &&
					st_r.quad_enable_bit) begin
					st_nxt.mode = MODE_QUAD; // R11
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= STATE_INIT; // R12
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o      = st_r.rdata;
	assign quad_mode_o  = (st_r.mode == MODE_QUAD);
	assign reset_busy_o = busy;
	assign op_abort_o   = st_r.abort;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_exit_quad_mode: assert property ( // R1
		take && st_r.mode == MODE_QUAD && ev_op == OP_EXIT_QUAD
		|=> st_r.mode == MODE_SERIAL && !quad_mode_o
	) else $error("exit opcode did not leave quad mode");

	a_exit_keeps_state: assert property ( // R2
		take && st_r.mode == MODE_QUAD && ev_op == OP_EXIT_QUAD && !wr_i
		|=> $stable(st_r.write_enable_latch) && $stable(st_r.suspend_status_bit)
			&& $stable(st_r.wrap_setting_bits)
	) else $error("quad exit changed latch, suspend or wrap");

	a_reset_clears_all: assert property ( // R3
		reset_fire
		|=> !st_r.write_enable_latch && !st_r.suspend_status_bit
			&& st_r.read_parameter_bits == RP_RESET
			&& st_r.continuous_read_mode_bits == CRM_RESET
			&& st_r.wrap_setting_bits == WRAP_RESET
			&& st_r.volatile_status == VSR_RESET
			&& st_r.mode == MODE_SERIAL && op_abort_o
		##1 !op_abort_o
	) else $error("reset left volatile state or abort wrong");

	a_enable_any_mode: assert property ( // R4
		take && ev_op == OP_RESET_ENABLE |=> st_r.reset_enabled
	) else $error("reset enable not taken");

	a_pair_only: assert property ( // R5
		$rose(busy) |-> $past(st_r.reset_enabled) && $past(ev_op) == OP_RESET
	) else $error("recovery started without enable and reset pair");

	a_enable_cancel: assert property ( // R6
		take && ev_op != OP_RESET_ENABLE |=> !st_r.reset_enabled
	) else $error("reset enable survived another command");

	a_recover_start: assert property ( // R8
		reset_fire |=> st_r.recover_cnt == RST_COUNT ##1 busy [*8]
	) else $error("recovery count wrong");

	a_busy_ignores: assert property ( // R8
		busy && ev_valid
		|=> $stable(st_r.mode) && $stable(st_r.reset_enabled) && $stable(st_r.last_opcode)
	) else $error("command acted on during recovery");

	a_quad_gate: assert property ( // R11
		take && st_r.mode == MODE_SERIAL && ev_op == OP_ENTER_QUAD && !st_r.quad_enable_bit
		|=> st_r.mode == MODE_SERIAL
	) else $error("quad entered with quad enable low");

	a_enable_cleared: assert property ( // R12
		$fell(busy) |-> !st_r.reset_enabled
	) else $error("reset enable still set after recovery");

	a_enter_quad_mode: assert property ( // R11
		take && st_r.mode == MODE_SERIAL && ev_op == OP_ENTER_QUAD && st_r.quad_enable_bit
		|=> quad_mode_o
	) else $error("enter opcode with quad enable set did not enter quad mode");

	a_abort_only_pair: assert property ( // R10
		op_abort_o |-> $past(reset_fire)
	) else $error("abort raised without an accepted reset pair");

	a_lone_reset_ignored: assert property ( // R5
		take && ev_op == OP_RESET && !st_r.reset_enabled |=> !busy && !op_abort_o
	) else $error("reset opcode without enable started recovery");

endmodule

//--- tb/host_link_model.sv
module host_link_model (
	output logic       link_clk_o, // serial clock, runs only inside frames
	output logic       cs_n_o,     // chip select, active low
	output logic [3:0] io_o        // data lines to the device
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		link_clk_o = 1'b0;
		cs_n_o     = 1'b1;
		io_o       = 4'h5;
	end

	// one opcode per frame, msb first; 64 ns link period
	task automatic send(input logic [7:0] op, input logic quad);
		int n;
		n = quad ? 2 : 8;
		cs_n_o = 1'b0;
		#7;
		for (int i = 0; i < n; i++) begin
			if (quad) begin
				io_o = (i == 0) ? op[7:4] : op[3:0];
			end else begin
				io_o = {{3{~op[7-i]}}, op[7-i]};
			end
			#32 link_clk_o = 1'b1;
			#32 link_clk_o = 1'b0;
		end
		#16 cs_n_o = 1'b1;
		// released lines must not keep the last value
		io_o = ~io_o;
	endtask
endmodule

//--- tb/tb_flash_mode_exit_and_soft_reset.sv
module tb_flash_mode_exit_and_soft_reset
	import flash_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              sys_clk_i;
	logic              reset_n_i;
	logic              en_i;
	logic              wr_i;
	logic              rd_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i;
	logic [DATA_W-1:0] rdata_o;
	logic [DATA_W-1:0] rd_val;
	logic              quad_mode_o;
	logic              reset_busy_o;
	logic              op_abort_o;
	logic              link_clk;
	logic              cs_n;
	logic [3:0]        io;
	int                n_fail;
	int                n_checks;

	flash_mode_ctrl u_flash_mode_ctrl (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .en_i(en_i),
		.link_clk_i(link_clk), .cs_n_i(cs_n), .io_i(io), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.quad_mode_o(quad_mode_o), .reset_busy_o(reset_busy_o), .op_abort_o(op_abort_o)
	);

	host_link_model u_host_link_model (.link_clk_o(link_clk), .cs_n_o(cs_n), .io_o(io));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic results();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		rd_val = rdata_o;
	endtask

	task automatic st(input logic [31:0] exp);
		rd(ADDR_STATUS);
		check(rd_val & 32'h0000_0007, exp);
	endtask

	// frame plus settle time for the sync and decode
	task automatic op(input logic [7:0] c, input logic q);
		u_host_link_model.send(c, q);
		repeat (10) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic t_reset_values();
		logic [7:0] a[7];
		a = '{ADDR_CTRL, ADDR_READ_PARAM, ADDR_CONT_READ, ADDR_WRAP, ADDR_VOL_STATUS,
			ADDR_STATUS, 8'h18};
		wr(8'h18, 32'hffff_ffff);
		foreach (a[i]) begin
			rd(a[i]);
			check(rd_val, 32'h0000_0000);
		end
		check({quad_mode_o, reset_busy_o, op_abort_o}, 32'h0000_0000);
	endtask

	task automatic t_quad_entry_exit();
		op(OP_ENTER_QUAD, 1'b0);
		check(quad_mode_o, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0007);
		wr(ADDR_WRAP, 32'h0000_0005);
		op(OP_EXIT_QUAD, 1'b0);
		check(quad_mode_o, 32'h0000_0000);
		op(OP_ENTER_QUAD, 1'b0);
		check(quad_mode_o, 32'h0000_0001);
		op(OP_EXIT_QUAD, 1'b1);
		check(quad_mode_o, 32'h0000_0000);
		rd(ADDR_CTRL);
		check(rd_val, 32'h0000_0007);
		rd(ADDR_WRAP);
		check(rd_val, 32'h0000_0005);
	endtask

	task automatic reset_seq(input logic q);
		time t0;
		int  w;
		op(OP_RESET_ENABLE, q);
		st({29'h0, 2'b01, q});
		w = 0;
		// the abort pulse is over before the frame's select rises, so watch alongside
		fork
			u_host_link_model.send(OP_RESET, q);
			begin
				while (op_abort_o !== 1'b1 && w < 200) begin
					@(posedge sys_clk_i);
					#1;
					w++;
				end
				t0 = $time;
				check({reset_busy_o, quad_mode_o, op_abort_o}, 32'h0000_0005);
				@(posedge sys_clk_i);
				#1;
				check(op_abort_o, 32'h0000_0000);
			end
		join
		// host sends during recovery; this enable must be dropped
		op(OP_RESET_ENABLE, 1'b0);
		st(32'h0000_0004);
		check(rd_val & 32'h0000_ff00, {16'h0000, OP_RESET, 8'h00});
		while (reset_busy_o === 1'b1 && w < 4000) begin
			@(posedge sys_clk_i);
			#1;
			w++;
		end
		check(32'(($time - t0) / CLK_PERIOD_NS), 32'(RST_COUNT));
		st(32'h0000_0000);
	endtask

	task automatic t_reset_cancel();
		op(OP_RESET_ENABLE, 1'b0);
		st(32'h0000_0002);
		op(8'h05, 1'b0);
		st(32'h0000_0000);
		check(rd_val & 32'h0000_ff00, 32'h0000_0500);
		op(OP_RESET, 1'b0);
		check(reset_busy_o, 32'h0000_0000);
		rd(ADDR_CTRL);
		check(rd_val, 32'h0000_0007);
		reset_seq(1'b0);
		rd(ADDR_CTRL);
		check(rd_val, 32'h0000_0001);
	endtask

	task automatic t_quad_reset();
		logic [7:0] a[4];
		a = '{ADDR_READ_PARAM, ADDR_CONT_READ, ADDR_WRAP, ADDR_VOL_STATUS};
		foreach (a[i]) begin
			wr(a[i], 32'h0000_0005);
		end
		wr(ADDR_CTRL, 32'h0000_0007);
		op(OP_ENTER_QUAD, 1'b0);
		check(quad_mode_o, 32'h0000_0001);
		rd(ADDR_CTRL);
		reset_seq(1'b1);
		foreach (a[i]) begin
			rd(a[i]);
			check(rd_val, 32'h0000_0000);
		end
		rd(ADDR_CTRL);
		check(rd_val, 32'h0000_0001);
	endtask

	initial begin
		reset_n_i = 1'b0;
		en_i      = 1'b1;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		addr_i    = '0;
		wdata_i   = '0;
		n_fail    = 0;
		n_checks  = 0;
		repeat (20) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		t_reset_values();
		t_quad_entry_exit();
		t_reset_cancel();
		t_quad_reset();
		results();
	end

	// two recoveries plus fourteen frames fit well inside this
	initial begin
		#500_000;
		n_fail++;
		results();
	end
endmodule
